// *** dv/serial_port_config_regs_monitor.sv ***
`timescale 1ns/1ns
module spc_config_monitor (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic                cs_n,
  input wire logic                sdio_oe_n,
  input wire logic                serial_data_out_pin_oe_n,
  input wire spc_pkg::bank_t      active_bank,
  input wire spc_pkg::port_mode_t port_mode
);
  import spc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_pins_exclusive: assert property (sdio_oe_n || serial_data_out_pin_oe_n)
    else $error("both data pins driven");
  a_three_wire: assert property (!port_mode.four_wire_select |-> serial_data_out_pin_oe_n)
    else $error("serial out driven in three-wire mode");
  a_four_wire: assert property (port_mode.four_wire_select |-> sdio_oe_n)
    else $error("data pin driven in four-wire mode");
  a_long_instr: assert property (port_mode.long_instr)
    else $error("long instruction bit cleared");
  a_reset_vals: assert property ($fell(rst) |->
    active_bank == BANK_RESET && port_mode == 4'h1)
    else $error("defaults missing after reset");
  a_soft_hold: assert property (port_mode.soft_reset [*2] |-> active_bank == BANK_RESET)
    else $error("active bank not held by soft reset");
  a_idle_stable: assert property (cs_n [*8] |->
    $stable(active_bank) && $stable(port_mode))
    else $error("state changed outside a frame");
  a_idle_quiet: assert property (cs_n [*8] |-> sdio_oe_n && serial_data_out_pin_oe_n)
    else $error("pin driven outside a frame");
endmodule
bind serial_port_config_regs spc_config_monitor u_spc_config_monitor (
  .sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sdio_oe_n(sdio_oe_n),
  .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n), .active_bank(active_bank),
  .port_mode(port_mode));

// *** dv/serial_port_config_regs_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module serial_port_config_regs_tb_top;
  import spc_pkg::*;
  localparam logic [7:0] ID = 8'hC4; // arbitrary value
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sclk;
  logic        cs_n;
  logic        sdio_i;
  logic        sdio_o;
  logic        sdio_oe_n;
  logic        serial_data_out_pin;
  logic        serial_data_out_pin_oe_n;
  bank_t       active_bank;
  port_mode_t  port_mode;
  logic [15:0] rd_v;
  int          errors = 0;
  int          n_tests = 0;
  always #25 sys_clk = ~sys_clk;
  serial_port_config_regs #(.VARIANT_ID(ID)) u_serial_port_config_regs (
    .sys_clk(sys_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i),
    .sdio_o(sdio_o), .sdio_oe_n(sdio_oe_n), .serial_data_out_pin_o(serial_data_out_pin),
    .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n), .active_bank(active_bank),
    .port_mode(port_mode));
  spc_host_model u_spc_host_model (
    .serial_data_out_pin(serial_data_out_pin),
    .serial_data_out_pin_oe_n(serial_data_out_pin_oe_n), .sdio_o(sdio_o),
    .sdio_oe_n(sdio_oe_n), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_i));
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    u_spc_host_model.xfer(1'b0, a, 1, {8'h00, d}, rd_v);
  endtask
  task automatic wr2(input logic [9:0] a, input logic [15:0] d);
    u_spc_host_model.xfer(1'b0, a, 2, d, rd_v);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string n);
    u_spc_host_model.xfer(1'b1, a, 1, 16'h0000, rd_v);
    `CHK(n, e, rd_v[7:0])
  endtask
  task automatic rd2c(input logic [9:0] a, input logic [15:0] e, input string n);
    u_spc_host_model.xfer(1'b1, a, 2, 16'h0000, rd_v);
    `CHK(n, e, rd_v)
  endtask
  task automatic t_reset();
    `CHK("active", BANK_RESET, active_bank)
    rdc(OFF_PORT_CFG, RST_PORT_CFG, "cfg");
    rdc(OFF_VCO_DIV, RST_VCO_DIV, "vco");
    rdc(OFF_READBACK, RST_READBACK, "rb");
    wr(OFF_VARIANT_ID, 8'h00);
    wr(10'h100, 8'hFF);
    rdc(OFF_VARIANT_ID, ID, "id");
    rdc(10'h100, 8'h00, "unmapped");
    $display("done reset");
  endtask
  task automatic t_commit();
    wr2(OFF_CLK_IN, 16'h050C);
    wr(OFF_PWR_SYNC, 8'h03);
    `CHK("held", BANK_RESET, active_bank)
    rdc(OFF_VCO_DIV, 8'h05, "buf");
    rd2c(OFF_CLK_IN, 16'h050C, "dec2");
    wr(OFF_READBACK, 8'h01);
    rdc(OFF_VCO_DIV, 8'h02, "act");
    wr(OFF_COMMIT, 8'h01);
    `CHK("commit", 8'h05, active_bank.vco_div)
    `CHK("commit_clk", 8'h0C, active_bank.clk_in)
    rdc(OFF_COMMIT, 8'h00, "selfclr");
    rdc(OFF_PWR_SYNC, 8'h03, "act2");
    wr(OFF_READBACK, 8'h00);
    $display("done commit");
  endtask
  task automatic t_modes();
    wr(OFF_PORT_CFG, 8'h81);
    `CHK("long", 1'b1, port_mode.long_instr)
    rdc(OFF_VCO_DIV, 8'h05, "four_rd");
    wr(OFF_PORT_CFG, 8'hDB);
    `CHK("lsb", 1'b1, port_mode.lsb_first)
    rdc(OFF_PWR_SYNC, 8'h03, "lsb4w");
    rd2c(OFF_VCO_DIV, 16'h0C05, "inc2");
    wr(OFF_PORT_CFG, 8'h5A);
    rdc(OFF_VCO_DIV, 8'h05, "lsb3w");
    wr(OFF_PORT_CFG, 8'h18);
    rdc(OFF_PORT_CFG, RST_PORT_CFG, "msb3w");
    $display("done modes");
  endtask
  task automatic t_soft();
    wr(OFF_PORT_CFG, 8'h3C);
    `CHK("sreset", BANK_RESET, active_bank)
    `CHK("sr_held", 1'b1, port_mode.soft_reset)
    rdc(OFF_VCO_DIV, RST_VCO_DIV, "sr_buf");
    wr(OFF_PORT_CFG, 8'h18);
    `CHK("sr_clr", 1'b0, port_mode.soft_reset)
    rdc(OFF_PWR_SYNC, RST_PWR_SYNC, "after");
    $display("done soft reset");
  endtask
  task automatic end_sim();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    t_reset();
    t_commit();
    t_modes();
    t_soft();
    end_sim();
  end
endmodule

// *** dv/spc_host_model.sv ***
`timescale 1ns/1ns
module spc_host_model (
  input  wire logic serial_data_out_pin,
  input  wire logic serial_data_out_pin_oe_n,
  input  wire logic sdio_o,
  input  wire logic sdio_oe_n,
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_i
);
  logic hd = 1'b0;
  logic hen = 1'b0;
  logic lsb_q = 1'b0;
  logic four_q = 1'b0;
  // wire level: device, host, else inverse of last bit
  assign sdio_i = !sdio_oe_n ? sdio_o : (hen ? hd : ~hd);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
  end
  // one bit per sclk period, half period 8 sys_clk
  task automatic bitx(input logic b, output logic r);
    hd = b;
    #400 sclk = 1'b1;
    // released serial out shows the inverse
    r = four_q ? (serial_data_out_pin_oe_n ? ~serial_data_out_pin : serial_data_out_pin)
               : sdio_i;
    #400 sclk = 1'b0;
  endtask
  // n data bytes, first byte in wd[7:0]
  task automatic xfer(input logic rd, input logic [9:0] a, input int n,
                      input logic [15:0] wd, output logic [15:0] rdat);
    logic [15:0] w;
    logic        r;
    w = {rd, 5'h00, a};
    rdat = 16'h0000;
    cs_n = 1'b0;
    hen = 1'b1;
    for (int i = 0; i < 16; i++) bitx(lsb_q ? w[i] : w[15-i], r);
    hen = !rd || four_q;
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 8; i++) begin
        bitx(lsb_q ? wd[8*k+i] : wd[8*k+7-i], r);
        rdat[lsb_q ? 8*k+i : 8*k+7-i] = r;
      end
    end
    #400 cs_n = 1'b1;
    hen = 1'b0;
    if (!rd && a == 10'h000) begin
      lsb_q = wd[1];
      four_q = wd[0];
    end
    // idle gap so the frame end is seen
    #400;
  endtask
endmodule

// *** logic/serial_port_config_regs.sv ***
`timescale 1ns/1ns
// Functional notes
// - Only 16-bit instructions exist; the long-instruction bit resets to 1 and stays 1.
// - Soft reset bit at 1 holds registers at defaults until the host writes it back to 0.
// - Bit order 0 gives MSB first and decrementing address; 1 gives LSB first, increment.
// - Output select 0 puts read data on the data pin and floats the serial output pin.
// - Output select 1 drives read data on the serial output pin; data pin only writes.
// - A read-only byte identifies which family variant is fitted.
// - Readback select 0 returns buffer registers; 1 returns active registers.
module serial_port_config_regs #(
  parameter logic [7:0] VARIANT_ID = spc_pkg::VARIANT_ID_DEFAULT // arbitrary value
) (
  input  wire logic          sys_clk,
  input  wire logic          rst,
  input  wire logic          sclk,
  input  wire logic          cs_n,
  input  wire logic          sdio_i,
  output logic               sdio_o,
  output logic               sdio_oe_n,
  output logic               serial_data_out_pin_o,
  output logic               serial_data_out_pin_oe_n,
  output spc_pkg::bank_t     active_bank,
  output spc_pkg::port_mode_t port_mode
);
  import spc_pkg::*;

  typedef enum logic [1:0] {ST_INSTR, ST_DATA} phase_t;

  logic [2:0] sclk_s_q;
  logic [1:0] cs_s_q;
  logic [1:0] din_s_q;
  logic       frame;
  logic       sclk_rise;
  logic       sclk_fall;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 2'h3;
      din_s_q  <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q   <= {cs_s_q[0], cs_n};
      din_s_q  <= {din_s_q[0], sdio_i};
    end
  end

  assign frame     = !cs_s_q[1];
  assign sclk_rise = sclk_s_q[1] && !sclk_s_q[2];
  assign sclk_fall = !sclk_s_q[1] && sclk_s_q[2];

  logic [7:0] port_cfg_q;
  logic [7:0] readback_q;
  logic [7:0] commit_q;
  bank_t      buf_q;
  bank_t      act_q;
  phase_t     phase_q;
  logic       rd_q;
  logic [1:0] instr_byte_q;
  logic [7:0] instr_hi_q;
  logic [9:0] addr_q;
  logic       drive_q;
  logic [7:0] rx_byte;
  logic       rx_done;
  logic       tx_bit;
  logic       wr_stb;
  logic       load;
  logic [7:0] rd_data;
  logic       soft_rst;
  logic       load_q;
  logic       instr_rd;

  spc_shifter u_shift (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .frame     (frame),
    .sclk_rise (sclk_rise),
    .sclk_fall (sclk_fall),
    .din       (din_s_q[1]),
    .lsb_first (port_cfg_q[BIT_LSB_FIRST]),
    .load      (load),
    .load_byte (rd_data),
    .rx_byte   (rx_byte),
    .rx_done   (rx_done),
    .tx_bit    (tx_bit)
  );

  function automatic logic [7:0] read_mux(input logic [9:0] a, input logic [7:0] cfg,
                                          input logic [7:0] rb, input bank_t b,
                                          input logic [7:0] id);
    case (a)
      OFF_PORT_CFG:   read_mux = cfg;
      OFF_VARIANT_ID: read_mux = id;
      OFF_READBACK:   read_mux = rb;
      OFF_VCO_DIV:    read_mux = b.vco_div;
      OFF_CLK_IN:     read_mux = b.clk_in;
      OFF_PWR_SYNC:   read_mux = b.pwr_sync;
      default:        read_mux = 8'h00;
    endcase
  endfunction

  assign rd_data = read_mux(addr_q, port_cfg_q, readback_q,
                            readback_q[BIT_RB_ACTIVE] ? act_q : buf_q, VARIANT_ID);

  assign soft_rst = port_cfg_q[BIT_SOFT_RST];
  assign wr_stb   = rx_done && (phase_q == ST_DATA) && !rd_q;
  assign instr_rd = port_cfg_q[BIT_LSB_FIRST] ? rx_byte[7] : instr_hi_q[7];
  assign load     = load_q;

  // reload once the address has settled
  always_ff @(posedge sys_clk) begin
    if (rst || !frame) begin
      load_q <= 1'b0;
    end else begin
      load_q <= rx_done && ((phase_q == ST_INSTR && instr_byte_q == 2'h1 && instr_rd) ||
                            (phase_q == ST_DATA && rd_q));
    end
  end

  // instruction and address sequencing
  always_ff @(posedge sys_clk) begin
    if (rst || !frame) begin
      phase_q      <= ST_INSTR;
      instr_byte_q <= 2'h0;
      instr_hi_q   <= 8'h00;
      rd_q         <= 1'b0;
      addr_q       <= 10'h000;
    end else if (rx_done) begin
      case (phase_q)
        ST_INSTR: begin
          if (instr_byte_q == 2'h0) begin
            instr_hi_q   <= rx_byte;
            instr_byte_q <= 2'h1;
          end else begin
            rd_q    <= instr_rd;
            addr_q  <= port_cfg_q[BIT_LSB_FIRST] ? {rx_byte[1:0], instr_hi_q}
                                                 : {instr_hi_q[1:0], rx_byte};
            phase_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          addr_q <= port_cfg_q[BIT_LSB_FIRST] ? addr_q + 10'h001 : addr_q - 10'h001;
        end
        default: phase_q <= ST_INSTR;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      port_cfg_q <= RST_PORT_CFG;
    end else if (wr_stb && addr_q == OFF_PORT_CFG) begin
      port_cfg_q <= {rx_byte[7:4], 1'b1, rx_byte[2:0]};
    end
  end

  // held at defaults during soft reset
  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      readback_q <= RST_READBACK;
      buf_q      <= BANK_RESET;
    end else if (wr_stb) begin
      if (addr_q == OFF_READBACK) readback_q <= {7'h00, rx_byte[BIT_RB_ACTIVE]};
      if (addr_q == OFF_VCO_DIV)  buf_q.vco_div  <= rx_byte;
      if (addr_q == OFF_CLK_IN)   buf_q.clk_in   <= rx_byte;
      if (addr_q == OFF_PWR_SYNC) buf_q.pwr_sync <= rx_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      commit_q <= RST_COMMIT;
    end else if (wr_stb && addr_q == OFF_COMMIT) begin
      commit_q <= {7'h00, rx_byte[BIT_COMMIT]};
    end else begin
      commit_q <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || soft_rst) begin
      act_q <= BANK_RESET;
    end else if (commit_q[BIT_COMMIT]) begin
      act_q <= buf_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !frame) begin
      drive_q <= 1'b0;
    end else if (sclk_fall && rd_q && phase_q == ST_DATA) begin
      drive_q <= 1'b1;
    end
  end

  assign sdio_o                   = tx_bit;
  assign sdio_oe_n                = !(drive_q && !port_cfg_q[BIT_FOUR_WIRE]);
  assign serial_data_out_pin_o    = tx_bit;
  assign serial_data_out_pin_oe_n = !(drive_q && port_cfg_q[BIT_FOUR_WIRE]);

  assign active_bank = act_q;
  assign port_mode   = '{four_wire_select: port_cfg_q[BIT_FOUR_WIRE],
                         lsb_first:        port_cfg_q[BIT_LSB_FIRST],
                         soft_reset:       port_cfg_q[BIT_SOFT_RST],
                         long_instr:       port_cfg_q[BIT_LONG_INS]};
endmodule

// *** logic/spc_pkg.sv ***
package spc_pkg;
  localparam int unsigned ADDR_W = 10;

  localparam logic [9:0] OFF_PORT_CFG   = 10'h000;
  localparam logic [9:0] OFF_VARIANT_ID = 10'h003;
  localparam logic [9:0] OFF_READBACK   = 10'h004;
  localparam logic [9:0] OFF_VCO_DIV    = 10'h1E0;
  localparam logic [9:0] OFF_CLK_IN     = 10'h1E1;
  localparam logic [9:0] OFF_PWR_SYNC   = 10'h230;
  localparam logic [9:0] OFF_RSVD       = 10'h231;
  localparam logic [9:0] OFF_COMMIT     = 10'h232;

  localparam logic [7:0] RST_PORT_CFG = 8'h18;
  localparam logic [7:0] RST_READBACK = 8'h00;
  localparam logic [7:0] RST_VCO_DIV  = 8'h02;
  localparam logic [7:0] RST_CLK_IN   = 8'h00;
  localparam logic [7:0] RST_PWR_SYNC = 8'h00;
  localparam logic [7:0] RST_RSVD     = 8'h00;
  localparam logic [7:0] RST_COMMIT   = 8'h00;

  localparam int unsigned BIT_FOUR_WIRE = 0;
  localparam int unsigned BIT_LSB_FIRST = 1;
  localparam int unsigned BIT_SOFT_RST  = 2;
  localparam int unsigned BIT_LONG_INS  = 3;
  localparam int unsigned BIT_RB_ACTIVE = 0;
  localparam int unsigned BIT_COMMIT    = 0;

  localparam int unsigned INSTR_BITS = 16;
  localparam int unsigned DATA_BITS  = 8;
  localparam logic [7:0]  VARIANT_ID_DEFAULT = 8'h5A; // arbitrary value

  typedef struct packed {
    logic [7:0] vco_div;
    logic [7:0] clk_in;
    logic [7:0] pwr_sync;
  } bank_t;

  typedef struct packed {
    logic       four_wire_select;
    logic       lsb_first;
    logic       soft_reset;
    logic       long_instr;
  } port_mode_t;

  localparam bank_t BANK_RESET = '{vco_div: 8'h02, clk_in: 8'h00, pwr_sync: 8'h00};
endpackage

// *** logic/spc_shifter.sv ***
`timescale 1ns/1ns
module spc_shifter (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       frame,
  input  wire logic       sclk_rise,
  input  wire logic       sclk_fall,
  input  wire logic       din,
  input  wire logic       lsb_first,
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  output logic [7:0]      rx_byte,
  output logic            rx_done,
  output logic            tx_bit
);
  import spc_pkg::*;

  logic [7:0] sh_q;
  logic [2:0] cnt_q;
  logic [7:0] tx_q;
  logic       out_q;

  always_ff @(posedge sys_clk) begin
    if (rst || !frame) begin
      sh_q  <= 8'h00;
      cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      sh_q  <= lsb_first ? {din, sh_q[7:1]} : {sh_q[6:0], din};
      cnt_q <= cnt_q + 3'h1;
    end
  end

  assign rx_byte = lsb_first ? {din, sh_q[7:1]} : {sh_q[6:0], din};
  assign rx_done = frame && sclk_rise && (cnt_q == 3'h7);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_q <= 8'h00;
    end else if (load) begin
      tx_q <= load_byte;
    end else if (sclk_fall) begin
      tx_q <= lsb_first ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
    end
  end

  // first bit goes out on the fall after load
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_q <= 1'b0;
    end else if (sclk_fall) begin
      out_q <= lsb_first ? tx_q[0] : tx_q[7];
    end
  end

  assign tx_bit = out_q;
endmodule
